// >>> verilog/iep_bank.sv
// Module: interrupt enable and priority register bank with Wishbone slave
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

// Operation
// - A source request passes only while its enable bit holds 1 and is blocked at 0.
// - Each 3-bit priority field is the level itself, 7 highest down to 1.
// - A priority field of zero blocks its source whatever the enable bit says.
// - Every priority field resets to binary 100, level 4.
// - All implemented enable bits reset to zero.
// - Enable bit 13 and bits 15, 11, 7 and 3 of each priority register read 0 and ignore writes.
// - Enable bits 15, 14, 12 to 9 and 8 are timer 6, DMA 4, output compare 8 to 5 and capture 6.
// - The first priority register holds CAN event, CAN receive, SPI event, SPI error fields.
// - The second priority register holds capture 5, capture 4, capture 3 and DMA 3 fields.
module iep_bank (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [5:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic        i_wb_we,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic [15:0] i_src_flag,
    output logic      [15:0] o_src_req,
    output logic             o_cpu_req,
    output logic      [3:0]  o_cpu_src,
    output logic      [2:0]  o_cpu_lvl,
    output logic             o_irq
);
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // 0x00 source enables, read/write, one bit per source
    // 0x04 first priority bank: CAN event, CAN receive, SPI event, SPI error
    // 0x08 second priority bank: capture 5, capture 4, capture 3, DMA 3
    // 0x0c status, read-only: bit 0 grant, bit 1 blocked flag
    // 0x10 clear, write-only: a 1 clears that status bit
    // 0x14 mask, read/write: selects status bits onto o_irq
    // 0x18 synchronised source flags, read-only
    // Field k of a priority bank sits at bits 4k+2 to 4k
    // Sources 15 to 8 have enables only and never enter selection
    // Upper byte lanes are ignored on write and read back as zero

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0] enable_q;
    logic [15:0] prio8_q;
    logic [15:0] prio9_q;
    logic [1:0]  status_q;
    logic [1:0]  status_d;
    logic [1:0]  mask_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        wr_stb;
    logic        rd_stb;
    logic        wr_enable;
    logic        wr_prio8;
    logic        wr_prio9;
    logic        wr_clear;
    logic        wr_mask;
    logic [15:0] req_d;
    logic [23:0] prio_flat;
    logic        grant_ev;
    logic        blocked_ev;
    // Synchroniser pair: only the second stage feeds logic
    logic [15:0] src_flag_meta_q;
    logic [15:0] src_flag_q;
    // Request path to the selector
    iep_arb_if   arb ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a 16-bit register, keeping only implemented bits
    // Lanes 2 and 3 are not wired; every register merged here is 16 bits wide
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  sel,
                                            input logic [15:0] impl);
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}};
        merge16 = ((new_v & lane) | (old_v & ~lane)) & impl;
    endfunction

    // Priority field k of one bank; used only for the four fields of each bank
    function automatic logic [2:0] field3(input logic [15:0] r, input int k);
        field3 = r[4*k +: 3];
    endfunction

    // Register hit for one byte address
    // Upper address bits must match too, so no register has an alias
    function automatic logic adr_is(input logic [5:0] adr, input logic [5:0] ofs);
        adr_is = (adr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------------
    // Flags come from peripherals that may sit on other clocks
    // Flags are levels; a pulse shorter than one clock may be lost
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            src_flag_meta_q <= 16'h0000;
            src_flag_q      <= 16'h0000;
        end else begin
            src_flag_meta_q <= i_src_flag;
            src_flag_q      <= src_flag_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------------
    // One wait state: ack follows the request by one edge, then drops
    // A request held past its ack is taken again two edges later
    // Nothing fires while ack is high, so a held cycle writes again only on every second edge
    assign wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
    assign rd_stb = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;

    // One strobe per writable register, high for the single taking edge
    assign wr_enable = wr_stb && adr_is(i_wb_adr, {2'h0, iep_pkg::SRC_ENABLE_2_OFS});
    assign wr_prio8  = wr_stb && adr_is(i_wb_adr, {2'h0, iep_pkg::SRC_PRIORITY_8_OFS});
    assign wr_prio9  = wr_stb && adr_is(i_wb_adr, {2'h0, iep_pkg::SRC_PRIORITY_9_OFS});
    // Clear and mask live in the low byte lane only
    assign wr_clear  = wr_stb && adr_is(i_wb_adr, iep_pkg::IRQ_CLEAR_ADR) && i_wb_sel[0];
    assign wr_mask   = wr_stb && adr_is(i_wb_adr, iep_pkg::IRQ_MASK_ADR) && i_wb_sel[0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
        end
    end

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------
    // enables cleared
    // Bit 13 is dropped at the write, so it can never read back set
    // bit 13 masked
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            enable_q <= iep_pkg::ENABLE_RESET;
        end else if (wr_enable) begin
            enable_q <= merge16(enable_q, i_wb_dat[15:0], i_wb_sel[1:0],
                                iep_pkg::ENABLE_IMPL);
        end
    end

    // ------------------------------------------------------------------
    // Priority registers
    // ------------------------------------------------------------------
    // fields load 100
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            prio8_q <= iep_pkg::PRIO_REG_RESET;
        end else if (wr_prio8) begin
            prio8_q <= merge16(prio8_q, i_wb_dat[15:0], i_wb_sel[1:0],
                               iep_pkg::PRIO_IMPL);
        end
    end

    // Second bank, same reset value and gap handling
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            prio9_q <= iep_pkg::PRIO_REG_RESET;
        end else if (wr_prio9) begin
            prio9_q <= merge16(prio9_q, i_wb_dat[15:0], i_wb_sel[1:0],
                               iep_pkg::PRIO_IMPL);
        end
    end

    // ------------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------------
    // first and second bank fields
    generate
        for (genvar k = 0; k < 4; k++) begin : g_field
            assign prio_flat[3*k +: 3]     = field3(prio8_q, k);
            assign prio_flat[3*(k+4) +: 3] = field3(prio9_q, k);
        end
    endgenerate

    // Gating is combinational; the output flops add one edge of latency
    // A zero field is cut here too, so o_src_req agrees with the selector
    // enable gate
    always_comb begin
        req_d = src_flag_q & enable_q;
        for (int i = 0; i < iep_pkg::NUM_PRIO; i++) begin
            if (prio_flat[3*i +: 3] == iep_pkg::PRIO_OFF) begin
                req_d[i] = 1'b0;
            end
        end
    end

    assign arb.req  = req_d;
    assign arb.prio = prio_flat;

    // Highest level wins; ties go to the lowest source index
    iep_prio_sel u_sel (
        .arb (arb.sel)
    );

    // ------------------------------------------------------------------
    // Outputs toward CPU arbitration
    // ------------------------------------------------------------------
    // Per-source view, high byte included
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_src_req <= 16'h0000;
        end else begin
            o_src_req <= req_d;
        end
    end

    // level passed unchanged
    // High byte sources carry no field here, so they are never presented to the CPU
    // Request, index and level move together, so the CPU never sees a mix
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_cpu_req <= 1'b0;
            o_cpu_src <= 4'h0;
            o_cpu_lvl <= 3'h0;
        end else begin
            o_cpu_req <= arb.any;
            o_cpu_src <= arb.src;
            o_cpu_lvl <= arb.lvl;
        end
    end

    // ------------------------------------------------------------------
    // Block status interrupt
    // ------------------------------------------------------------------
    // Grant: a graded request appears; blocked: a flag is held back
    assign grant_ev   = arb.any && !o_cpu_req;
    assign blocked_ev = |(src_flag_q & ~req_d);

    // Set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr_clear) begin
            status_d = status_q & ~i_wb_dat[1:0];
        end
        status_d[iep_pkg::EV_GRANT]   = status_d[iep_pkg::EV_GRANT] | grant_ev;
        status_d[iep_pkg::EV_BLOCKED] = status_d[iep_pkg::EV_BLOCKED] | blocked_ev;
    end

    // Sticky status bits
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            status_q <= 2'h0;
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt mask, written in the low lane only
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mask_q <= 2'h0;
        end else if (wr_mask) begin
            mask_q <= i_wb_dat[1:0];
        end
    end

    assign o_irq = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped and write-only addresses read zero, still acknowledged
    // Data is registered, so it stands from the ack edge until the next read
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd_stb) begin
            unique case (i_wb_adr)
                {2'h0, iep_pkg::SRC_ENABLE_2_OFS}:   rdat_q <= {16'h0000, enable_q};
                {2'h0, iep_pkg::SRC_PRIORITY_8_OFS}: rdat_q <= {16'h0000, prio8_q};
                {2'h0, iep_pkg::SRC_PRIORITY_9_OFS}: rdat_q <= {16'h0000, prio9_q};
                {2'h0, iep_pkg::IRQ_STATUS_OFS}:     rdat_q <= {30'h0, status_q};
                iep_pkg::IRQ_MASK_ADR:               rdat_q <= {30'h0, mask_q};
                iep_pkg::FLAG_ADR:                   rdat_q <= {16'h0000, src_flag_q};
                default:                             rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign o_wb_dat = rdat_q;
    assign o_wb_ack = ack_q;
endmodule

// >>> include/iep_pkg.sv
// Package: register map, field layout and reset values of the interrupt enable/priority bank
package iep_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the Wishbone slave)
    // ------------------------------------------------------------------
    localparam logic [3:0] SRC_ENABLE_2_OFS   = 4'h0;
    localparam logic [3:0] SRC_PRIORITY_8_OFS = 4'h4;
    localparam logic [3:0] SRC_PRIORITY_9_OFS = 4'h8;
    localparam logic [3:0] IRQ_STATUS_OFS     = 4'hc;
    localparam logic [5:0] IRQ_CLEAR_ADR      = 6'h10;
    localparam logic [5:0] IRQ_MASK_ADR       = 6'h14;
    localparam logic [5:0] FLAG_ADR           = 6'h18;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_SRC        = 16;
    localparam int          NUM_PRIO       = 8;
    localparam logic [15:0] ENABLE_IMPL    = 16'hdfff;
    localparam logic [15:0] PRIO_IMPL      = 16'h7777;
    localparam logic [15:0] ENABLE_RESET   = 16'h0000;
    localparam logic [2:0]  PRIO_RESET     = 3'h4;
    localparam logic [15:0] PRIO_REG_RESET = 16'h4444;
    localparam logic [2:0]  PRIO_OFF       = 3'h0;
    // Enable bit of each source that has a priority field, field k at bits 4k+2:4k
    localparam logic [3:0]  PRIO8_SRC [4]  = '{4'h3, 4'h2, 4'h1, 4'h0};
    localparam logic [3:0]  PRIO9_SRC [4]  = '{4'h7, 4'h6, 4'h5, 4'h4};
    // Status events of the bus slave
    localparam int          EV_GRANT       = 0;
    localparam int          EV_BLOCKED     = 1;
    localparam int          NUM_EV         = 2;
endpackage

// >>> include/iep_arb_if.sv
// Interface: request path between the register bank and the priority selector
`timescale 1ns/1ps
interface iep_arb_if;
    logic [15:0] req;
    logic [23:0] prio;
    logic        any;
    logic [3:0]  src;
    logic [2:0]  lvl;
    modport bank (output req, output prio, input any, input src, input lvl);
    modport sel  (input req, input prio, output any, output src, output lvl);
endinterface

// >>> verilog/iep_prio_sel.sv
// Module: picks the highest-priority presented request
`timescale 1ns/1ps
module iep_prio_sel (
    iep_arb_if.sel    arb
);
    // ------------------------------------------------------------------
    // Selection: highest level wins, lowest source index breaks ties
    // ------------------------------------------------------------------
    always_comb begin
        arb.any = 1'b0;
        arb.src = 4'h0;
        arb.lvl = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (arb.req[i] && (arb.prio[3*i +: 3] > arb.lvl)) begin
                arb.any = 1'b1;
                arb.src = 4'(i);
                arb.lvl = arb.prio[3*i +: 3];
            end
        end
    end
endmodule

// >>> tb/iep_src_model.sv
// Partner model: peripheral sources raising their interrupt flags
`timescale 1ns/1ps
module iep_src_model (
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_want,
    output logic      [15:0] o_flag
);
    // Flags launched on the clock, as a real peripheral would
    always_ff @(posedge i_sys_clk) begin
        o_flag <= i_want;
    end
endmodule

// >>> tb/iep_bank_sva.sv
// Checker: bus and request-path properties of the enable/priority bank
`timescale 1ns/1ps
module iep_bank_sva (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [5:0]  i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0]  i_wb_sel,
    input wire logic        i_wb_we,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic [15:0] i_src_flag,
    input wire logic [15:0] o_src_req,
    input wire logic        o_cpu_req,
    input wire logic [3:0]  o_cpu_src,
    input wire logic [2:0]  o_cpu_lvl,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Read answer while the request is still held
    wire logic rd_ack = o_wb_ack && !i_wb_we;
    // Bus ack is a one-cycle pulse, one cycle after the request
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing");
    AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    AST_RD_EN: assert property (rd_ack && i_wb_adr == 6'h00
        |-> (o_wb_dat & 32'hffff2000) == 0) else $error("enable reserved bit set");
    AST_RD_PRIO: assert property (rd_ack && (i_wb_adr == 6'h04 || i_wb_adr == 6'h08)
        |-> (o_wb_dat & 32'hffff8888) == 0) else $error("priority reserved bit set");
    AST_REQ_GATED: assert property ((o_src_req & ~$past(i_src_flag, 3)) == 16'h0)
        else $error("request without flag");
    AST_CPU_LVL: assert property (o_cpu_req |-> o_cpu_lvl != 3'h0)
        else $error("zero level presented");
    // presented source is a live graded request
    AST_CPU_SRC: assert property (o_cpu_req |-> !o_cpu_src[3] && o_src_req[o_cpu_src])
        else $error("presented source not requesting");
    AST_CPU_ANY: assert property (o_cpu_req == (o_src_req[7:0] != 8'h0))
        else $error("cpu request mismatch");
    COV_CPU: cover property ($rose(o_cpu_req));
    COV_IRQ: cover property ($rose(o_irq));
    COV_RDP: cover property (rd_ack && i_wb_adr == 6'h04);
endmodule

// >>> tb/test_irq_enable_priority_bank.sv
// Testbench: register, gating and interrupt checks of the enable/priority bank
`timescale 1ns/1ps
module test_irq_enable_priority_bank;
    logic        i_sys_clk   = 1'b0;
    logic        i_rst_n     = 1'b0;
    logic [5:0]  adr         = 6'h00;
    logic [31:0] wdat        = 32'h0;
    logic        we          = 1'b0;
    logic        cyc         = 1'b0;
    logic [3:0]  sel         = 4'h3;
    logic [15:0] want        = 16'h0;
    logic [15:0] flag, src_req, en, p8, p9, rd;
    logic [31:0] rdat;
    logic        ack, cpu_req, irq;
    logic [3:0]  cpu_src;
    logic [2:0]  cpu_lvl;
    logic [23:0] e;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          seed        = 15;
    always #25 i_sys_clk = ~i_sys_clk;
    iep_src_model i_src (.i_sys_clk(i_sys_clk), .i_want(want), .o_flag(flag));
    iep_bank i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(cyc), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_src_flag(flag), .o_src_req(src_req), .o_cpu_req(cpu_req),
        .o_cpu_src(cpu_src), .o_cpu_lvl(cpu_lvl), .o_irq(irq));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled high at a rising edge,
    // take read data at that edge, and release right after it
    task automatic bus(input logic [5:0] a, input logic w, input logic [15:0] d,
                       input logic [3:0] s = 4'h3);
        int k;
        @(posedge i_sys_clk);
        adr <= a;
        we <= w;
        sel <= s;
        wdat <= {16'h0, d};
        cyc <= 1'b1;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            test_done();
        end
        rd = rdat[15:0];
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    // Expected gating and selection: highest level, ties to lowest index
    function automatic logic [23:0] model(input logic [15:0] f);
        logic [15:0] r;
        logic [2:0]  l, best;
        logic [3:0]  s;
        best = 3'h0;
        s = 4'h0;
        r = f & en;
        for (int i = 0; i < 8; i++) begin
            l = (i < 4) ? p8[4*i +: 3] : p9[4*(i-4) +: 3];
            if (l == 3'h0) r[i] = 1'b0;
            if (r[i] && l > best) begin
                best = l;
                s = i[3:0];
            end
        end
        return {best != 3'h0, s, best, r};
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog at 20000 cycles, well beyond the expected fewer than 1100
    initial begin
        #1000000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        bus(6'h00, 1'b0, 16'h0);
        check(rd, 16'h0000);
        bus(6'h04, 1'b0, 16'h0);
        check(rd, 16'h4444);
        bus(6'h08, 1'b0, 16'h0);
        check(rd, 16'h4444);
        bus(6'h3c, 1'b0, 16'h0);
        check(rd, 16'h0000);
        // First pass is the corner: reserved-only first bank, level 7 second bank, all sources flagged
        for (int t = 0; t < 40; t++) begin
            en = (t == 0) ? 16'hffff : 16'($random(seed));
            p8 = (t == 0) ? 16'h8888 : 16'($random(seed));
            p9 = (t == 0) ? 16'hffff : 16'($random(seed));
            bus(6'h00, 1'b1, en);
            bus(6'h04, 1'b1, p8);
            bus(6'h08, 1'b1, p9);
            en = en & 16'hdfff;
            p8 = p8 & 16'h7777;
            p9 = p9 & 16'h7777;
            bus(6'h00, 1'b0, 16'h0);
            check(rd, en);
            bus(6'h04, 1'b0, 16'h0);
            check(rd, p8);
            bus(6'h08, 1'b0, 16'h0);
            check(rd, p9);
            @(posedge i_sys_clk);
            want <= (t == 0) ? 16'hffff : 16'($random(seed));
            repeat (6) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            e = model(want);
            check(src_req, e[15:0]);
            check({8'h0, cpu_req, cpu_src & {4{cpu_req}}, cpu_lvl & {3{cpu_req}}},
                {8'h0, e[23:16]});
        end
        // Interrupt: raise, mask, unmask, clear
        @(posedge i_sys_clk);
        want <= 16'h0;
        repeat (6) @(posedge i_sys_clk);
        bus(6'h10, 1'b1, 16'h0003);
        bus(6'h14, 1'b1, 16'h0000);
        bus(6'h0c, 1'b0, 16'h0);
        check(rd, 16'h0000);
        bus(6'h00, 1'b1, 16'h0001);
        bus(6'h04, 1'b1, 16'h0004);
        @(posedge i_sys_clk);
        want <= 16'h0001;
        repeat (6) @(posedge i_sys_clk);
        bus(6'h0c, 1'b0, 16'h0);
        check(rd, 16'h0001);
        check({15'h0, irq}, 16'h0);
        bus(6'h14, 1'b1, 16'h0001);
        @(negedge i_sys_clk);
        check({15'h0, irq}, 16'h1);
        @(posedge i_sys_clk);
        want <= 16'h0;
        repeat (6) @(posedge i_sys_clk);
        bus(6'h10, 1'b1, 16'h0001);
        @(negedge i_sys_clk);
        check({15'h0, irq}, 16'h0);
        // Disabled flag: blocked bit only, kept off the line by the mask
        @(posedge i_sys_clk);
        want <= 16'h0002;
        repeat (6) @(posedge i_sys_clk);
        bus(6'h18, 1'b0, 16'h0);
        check(rd, 16'h0002);
        bus(6'h0c, 1'b0, 16'h0);
        check(rd, 16'h0002);
        @(negedge i_sys_clk);
        check({15'h0, irq}, 16'h0);
        // Set wins over a clear while the blocked flag persists
        bus(6'h10, 1'b1, 16'h0002);
        bus(6'h0c, 1'b0, 16'h0);
        check(rd, 16'h0002);
        // High lane only: low byte kept, bit 13 still dropped
        bus(6'h00, 1'b1, 16'hffff, 4'h2);
        bus(6'h00, 1'b0, 16'h0);
        check(rd, 16'hdf01);
        test_done();
    end
endmodule
bind iep_bank iep_bank_sva i_sva (.*);
